// [logic/scp_pkg.sv]
/*
  Package of the serial control port slave: frame layout, address fields and widths.
  Assumes one system clock much faster than the host's shift clock.
*/
// Notes on behaviour
// - After reset the port is in two-wire mode; three low pulses on the select pin switch it to four-wire mode.
// - The four-wire port uses select, shift clock, serial in and serial out, and the device is always the slave.
// - Serial input is sampled on each rising shift-clock edge.
// - Serial output changes on falling shift-clock edges so the host can take it on the next rising edge.
// - Serial output stays high-impedance unless a read has been requested.
// - Every byte travels most significant bit first in both directions.
// - Once in four-wire mode the port stays there until a full reset.
// - The first byte holds a seven-bit device address, six zero bits above the address-select pin, then the direction.
// - The device answers address 0 with the address-select pin low and address 1 with it high.
// - The lowest bit of the first byte is 1 for a read and 0 for a write.
// - Bytes two and three form a twelve-bit subaddress naming a memory or register location.
// - Data bytes follow for consecutive locations until select rises, with a per-location byte count.
// - In a read the serial output starts to be driven at the start of the fourth byte.
package scp_pkg;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned SUB_W        = 12;
  localparam int unsigned IDX_W        = 3;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam logic [1:0]  SWITCH_PULSES = 2'h3;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [1:0]  BYTE_DEVADDR = 2'h0;
  localparam logic [1:0]  BYTE_SUBHI   = 2'h1;
  localparam logic [1:0]  BYTE_SUBLO   = 2'h2;
  localparam logic [1:0]  BYTE_DATA    = 2'h3;
  localparam logic [5:0]  DEVADDR_HIGH = 6'h00;
  localparam int unsigned RW_BIT       = 0;
  localparam int unsigned SUBHI_W      = 4;
  typedef logic [SUB_W-1:0] scp_sub_t;
endpackage

// [logic/scp_sync.sv]
/*
  Two-flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk_sys.
*/
module scp_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  always_comb begin
    nxt_stage1 = pinIn;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '1;
      stage2_ff <= '1;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;
endmodule

// [logic/scp_slave.sv]
/*
  Serial control port slave: mode switch, frame decode, subaddress walk, read-back shifting.
  Assumes the host keeps the shift clock well below a quarter of clk_sys and that internal
  logic returns read data one clk_sys cycle after a read request.
*/
module scp_slave (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Host pins
  input  wire logic                  select_or_write_protect_pin,
  input  wire logic                  control_shift_clock,
  input  wire logic                  control_serial_in,
  output logic                       control_serial_out,
  output logic                       control_serial_out_oe_n,
  input  wire logic                  address_select_pin,
  // Mode
  output logic                       spiModeActive,
  // Internal access port
  input  wire logic [scp_pkg::IDX_W-1:0] bytesPerLoc,
  output scp_pkg::scp_sub_t          accessAddr,
  output logic [scp_pkg::IDX_W-1:0]  accessIdx,
  output logic [scp_pkg::BYTE_W-1:0] wrData,
  output logic                       wrStrobe,
  output logic                       rdReq,
  input  wire logic [scp_pkg::BYTE_W-1:0] rdData
);
  import scp_pkg::*;

  // ********************************************************************
  // Pin synchronisation
  // ********************************************************************
  logic [3:0] pinSync;
  logic       selS;
  logic       clkS;
  logic       dinS;
  logic       adrS;

  scp_sync #(.WIDTH(4)) uSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({select_or_write_protect_pin, control_shift_clock, control_serial_in, address_select_pin}),
    .syncOut (pinSync)
  );
  assign {selS, clkS, dinS, adrS} = pinSync;

  // ********************************************************************
  // State
  // ********************************************************************
  logic                 selPrev_ff, nxt_selPrev;
  logic                 clkPrev_ff, nxt_clkPrev;
  logic [1:0]           pulseCnt_ff, nxt_pulseCnt;
  logic                 spiMode_ff, nxt_spiMode;
  logic [2:0]           bitCnt_ff, nxt_bitCnt;
  logic [1:0]           byteCnt_ff, nxt_byteCnt;
  logic [BYTE_W-1:0]    rxShift_ff, nxt_rxShift;
  logic [BYTE_W-1:0]    txShift_ff, nxt_txShift;
  logic                 matched_ff, nxt_matched;
  logic                 isRead_ff, nxt_isRead;
  logic                 drive_ff, nxt_drive;
  logic [SUBHI_W-1:0]   subHi_ff, nxt_subHi;
  scp_sub_t             locAddr_ff, nxt_locAddr;
  logic [IDX_W-1:0]     byteIdx_ff, nxt_byteIdx;
  scp_sub_t             accAddr_ff, nxt_accAddr;
  logic [IDX_W-1:0]     accIdx_ff, nxt_accIdx;
  logic [BYTE_W-1:0]    wrData_ff, nxt_wrData;
  logic                 wrStb_ff, nxt_wrStb;
  logic                 rdReq_ff, nxt_rdReq;

  logic              selFall;
  logic              sclkRise;
  logic              sclkFall;
  logic              inFrame;
  logic [BYTE_W-1:0] rxByte;
  logic [IDX_W-1:0]  idxInc;

  always_comb begin
    selFall  = selPrev_ff && !selS;
    sclkRise = !clkPrev_ff && clkS;
    sclkFall = clkPrev_ff && !clkS;
    inFrame  = spiMode_ff && !selS;
    rxByte   = {rxShift_ff[BYTE_W-2:0], dinS};
    idxInc   = byteIdx_ff + 3'h1;

    nxt_selPrev  = selS;
    nxt_clkPrev  = clkS;
    nxt_pulseCnt = pulseCnt_ff;
    nxt_spiMode  = spiMode_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_byteCnt  = byteCnt_ff;
    nxt_rxShift  = rxShift_ff;
    nxt_txShift  = txShift_ff;
    nxt_matched  = matched_ff;
    nxt_isRead   = isRead_ff;
    nxt_drive    = drive_ff;
    nxt_subHi    = subHi_ff;
    nxt_locAddr  = locAddr_ff;
    nxt_byteIdx  = byteIdx_ff;
    nxt_accAddr  = accAddr_ff;
    nxt_accIdx   = accIdx_ff;
    nxt_wrData   = wrData_ff;
    nxt_wrStb    = 1'b0;
    nxt_rdReq    = 1'b0;

    // Mode switch: counted only in two-wire mode, never undone
    if (!spiMode_ff && selFall) begin
      nxt_pulseCnt = pulseCnt_ff + 2'h1;
      if (pulseCnt_ff + 2'h1 == SWITCH_PULSES) begin
        nxt_spiMode = 1'b1;
      end
    end

    if (!inFrame) begin
      nxt_bitCnt  = '0;
      nxt_byteCnt = BYTE_DEVADDR;
      nxt_matched = 1'b0;
      nxt_isRead  = 1'b0;
      nxt_drive   = 1'b0;
    end else begin
      if (sclkRise) begin
        nxt_rxShift = rxByte;
        nxt_bitCnt  = bitCnt_ff + 3'h1;
        if (bitCnt_ff == LAST_BIT) begin
          if (byteCnt_ff != BYTE_DATA) begin
            nxt_byteCnt = byteCnt_ff + 2'h1;
          end
          unique case (byteCnt_ff)
            BYTE_DEVADDR: begin
              nxt_matched = (rxByte[BYTE_W-1:1] == {DEVADDR_HIGH, adrS});
              nxt_isRead  = rxByte[RW_BIT];
            end
            BYTE_SUBHI: begin
              nxt_subHi = rxByte[SUBHI_W-1:0];
            end
            BYTE_SUBLO: begin
              nxt_locAddr = {subHi_ff, rxByte};
              nxt_byteIdx = '0;
              nxt_accAddr = {subHi_ff, rxByte};
              nxt_accIdx  = '0;
              nxt_rdReq   = matched_ff && isRead_ff;
            end
            BYTE_DATA: begin
              if (matched_ff && !isRead_ff) begin
                nxt_wrData  = rxByte;
                nxt_wrStb   = 1'b1;
                nxt_accAddr = locAddr_ff;
                nxt_accIdx  = byteIdx_ff;
              end
              if (idxInc >= bytesPerLoc) begin
                nxt_byteIdx = '0;
                nxt_locAddr = locAddr_ff + 12'h001;
              end else begin
                nxt_byteIdx = idxInc;
              end
              if (matched_ff && isRead_ff) begin
                nxt_accAddr = (idxInc >= bytesPerLoc) ? locAddr_ff + 12'h001 : locAddr_ff;
                nxt_accIdx  = (idxInc >= bytesPerLoc) ? '0 : idxInc;
                nxt_rdReq   = 1'b1;
              end
            end
          endcase
        end
      end
      if (sclkFall && matched_ff && isRead_ff && byteCnt_ff == BYTE_DATA) begin
        nxt_drive = 1'b1;
        if (bitCnt_ff == '0) begin
          nxt_txShift = rdData;
        end else begin
          nxt_txShift = {txShift_ff[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      selPrev_ff  <= 1'b1;
      clkPrev_ff  <= 1'b1;
      pulseCnt_ff <= '0;
      spiMode_ff  <= 1'b0;
      bitCnt_ff   <= '0;
      byteCnt_ff  <= BYTE_DEVADDR;
      rxShift_ff  <= '0;
      txShift_ff  <= '0;
      matched_ff  <= 1'b0;
      isRead_ff   <= 1'b0;
      drive_ff    <= 1'b0;
      subHi_ff    <= '0;
      locAddr_ff  <= '0;
      byteIdx_ff  <= '0;
      accAddr_ff  <= '0;
      accIdx_ff   <= '0;
      wrData_ff   <= '0;
      wrStb_ff    <= 1'b0;
      rdReq_ff    <= 1'b0;
    end else begin
      selPrev_ff  <= nxt_selPrev;
      clkPrev_ff  <= nxt_clkPrev;
      pulseCnt_ff <= nxt_pulseCnt;
      spiMode_ff  <= nxt_spiMode;
      bitCnt_ff   <= nxt_bitCnt;
      byteCnt_ff  <= nxt_byteCnt;
      rxShift_ff  <= nxt_rxShift;
      txShift_ff  <= nxt_txShift;
      matched_ff  <= nxt_matched;
      isRead_ff   <= nxt_isRead;
      drive_ff    <= nxt_drive;
      subHi_ff    <= nxt_subHi;
      locAddr_ff  <= nxt_locAddr;
      byteIdx_ff  <= nxt_byteIdx;
      accAddr_ff  <= nxt_accAddr;
      accIdx_ff   <= nxt_accIdx;
      wrData_ff   <= nxt_wrData;
      wrStb_ff    <= nxt_wrStb;
      rdReq_ff    <= nxt_rdReq;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign control_serial_out      = txShift_ff[BYTE_W-1];
  assign control_serial_out_oe_n = !drive_ff;
  assign spiModeActive           = spiMode_ff;
  assign accessAddr              = accAddr_ff;
  assign accessIdx               = accIdx_ff;
  assign wrData                  = wrData_ff;
  assign wrStrobe                = wrStb_ff;
  assign rdReq                   = rdReq_ff;
endmodule

// [tb/scp_slave_sva.sv]
/* Checker of the serial control port slave pins and strobes.
   Assumes a host shift clock with phases of at least 8 clk_sys cycles. */
module scp_slave_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host pins
  input wire logic select_or_write_protect_pin,
  input wire logic control_shift_clock,
  input wire logic control_serial_out,
  input wire logic control_serial_out_oe_n,
  // Mode and strobes
  input wire logic spiModeActive,
  input wire logic wrStrobe,
  input wire logic rdReq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence selIdle;
    select_or_write_protect_pin [*6];
  endsequence
  sequence outMoves;
    !control_serial_out_oe_n && $changed(control_serial_out);
  endsequence
  a_twowire_released: assert property (!spiModeActive |-> control_serial_out_oe_n)
    else $error("output driven outside four-wire mode");
  a_twowire_quiet: assert property (!spiModeActive |-> !wrStrobe && !rdReq)
    else $error("access made in two-wire mode");
  a_mode_sticky: assert property (spiModeActive |=> spiModeActive)
    else $error("four-wire mode left without reset");
  a_dir_exclusive: assert property (!(wrStrobe && rdReq))
    else $error("read and write in one cycle");
  a_wr_single: assert property (wrStrobe |=> !wrStrobe)
    else $error("write strobe longer than one cycle");
  a_rd_spacing: assert property (rdReq |=> !rdReq [*8])
    else $error("read requests too close");
  a_idle_release: assert property (selIdle |-> control_serial_out_oe_n)
    else $error("output still driven after deselect");
  a_out_on_fall: assert property (outMoves |-> !control_shift_clock)
    else $error("output changed while shift clock high");
endmodule

bind scp_slave scp_slave_sva u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .select_or_write_protect_pin(select_or_write_protect_pin),
  .control_shift_clock(control_shift_clock), .control_serial_out(control_serial_out),
  .control_serial_out_oe_n(control_serial_out_oe_n), .spiModeActive(spiModeActive),
  .wrStrobe(wrStrobe), .rdReq(rdReq)
);

// [tb/scp_host_model.sv]
/* Host master model for the four-wire control port.
   Assumes calls start at a falling clk_sys edge; shift clock idles high. */
module scp_host_model (
  // Timing reference
  input  wire logic clk_sys,
  // Host pins
  output logic      select_or_write_protect_pin,
  output logic      control_shift_clock,
  output logic      control_serial_in,
  input  wire logic control_serial_out,
  input  wire logic control_serial_out_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80;
  initial begin
    select_or_write_protect_pin = 1'b1;
    control_shift_clock = 1'b1;
    control_serial_in = 1'b0;
  end
  task automatic pulseSel();
    @(negedge clk_sys);
    select_or_write_protect_pin = 1'b0;
    #HALF select_or_write_protect_pin = 1'b1;
    #HALF;
  endtask
  // Host is always master, the device answers on the readback line
  task automatic frame(input logic [63:0] tx, input int nBytes, output logic [63:0] rx);
    rx = '0;
    @(negedge clk_sys);
    select_or_write_protect_pin = 1'b0;
    #HALF;
    for (int i = nBytes * 8 - 1; i >= 0; i--) begin
      control_shift_clock = 1'b0;
      control_serial_in = tx[i];
      #HALF control_shift_clock = 1'b1;
      rx[i] = control_serial_out_oe_n ? 1'bx : control_serial_out;
      #HALF;
    end
    select_or_write_protect_pin = 1'b1;
    control_serial_in = ~control_serial_in;
    #(2 * HALF);
  endtask
endmodule

// [tb/spi_control_port_slave_tb.sv]
/* Testbench of the serial control port slave.
   Assumes the host model drives the pins and this module models internal memory. */
module spi_control_port_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scp_pkg::*;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   selPin, sclk, mosi, miso, misoOeN, modeOn, wrStrobe, rdReq;
  logic                   addrPin = 1'b0;
  logic                   oeSeen = 1'b0;
  logic [IDX_W-1:0]       bytesPerLoc = 3'h1;
  logic [IDX_W-1:0]       accessIdx;
  logic [BYTE_W-1:0]      wrData;
  logic [BYTE_W-1:0]      rdData = 8'h00;
  scp_sub_t               accessAddr;
  logic [22:0]            wrLog [8];
  logic [63:0]            rx;
  int                     n_errors = 0, cmp_count = 0, wrCount = 0, rdCount = 0;
  always #5 clk_sys = ~clk_sys;
  scp_host_model host (.clk_sys(clk_sys), .select_or_write_protect_pin(selPin), .control_shift_clock(sclk),
    .control_serial_in(mosi), .control_serial_out(miso), .control_serial_out_oe_n(misoOeN));
  scp_slave DUT (.clk_sys(clk_sys), .rst_n(rst_n), .select_or_write_protect_pin(selPin),
    .control_shift_clock(sclk), .control_serial_in(mosi), .control_serial_out(miso),
    .control_serial_out_oe_n(misoOeN), .address_select_pin(addrPin), .spiModeActive(modeOn),
    .bytesPerLoc(bytesPerLoc), .accessAddr(accessAddr), .accessIdx(accessIdx), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdReq(rdReq), .rdData(rdData));
  // Internal memory: read byte is derived from the location and index
  always @(negedge clk_sys) begin
    if (rdReq) begin
      rdData <= accessAddr[7:0] ^ {5'h00, accessIdx} ^ 8'h5a;
      rdCount <= rdCount + 1;
    end
    if (wrStrobe) begin
      wrLog[wrCount[2:0]] <= {accessAddr, accessIdx, wrData};
      wrCount <= wrCount + 1;
    end
    if (!misoOeN) oeSeen <= 1'b1;
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_mode();
    host.frame(64'h00_01_23_11, 4, rx);
    check("writes in two-wire mode", wrCount, 0);
    check("drive in two-wire mode", oeSeen, 1'b0);
    host.pulseSel();
    check("mode after two pulses", modeOn, 1'b0);
    host.pulseSel();
    check("mode after three pulses", modeOn, 1'b1);
  endtask
  task automatic test_write();
    bytesPerLoc = 3'h2;
    host.frame(64'h00_01_23_a1_b2_c3, 6, rx);
    check("write count", wrCount, 3);
    check("first write", wrLog[0], {12'h123, 3'h0, 8'ha1});
    check("second write", wrLog[1], {12'h123, 3'h1, 8'hb2});
    check("third write", wrLog[2], {12'h124, 3'h0, 8'hc3});
    check("drive during write", oeSeen, 1'b0);
  endtask
  task automatic test_mismatch();
    int wr0;
    wr0 = wrCount;
    host.frame(64'h03_00_10_00, 4, rx);
    host.frame(64'h02_00_10_55, 4, rx);
    check("stray reads", rdCount, 0);
    check("stray writes", wrCount - wr0, 0);
    check("stray drive", oeSeen, 1'b0);
  endtask
  task automatic test_read();
    int wr0;
    wr0 = wrCount;
    addrPin = 1'b1;
    bytesPerLoc = 3'h1;
    host.frame(64'h03_00_40_00_00, 5, rx);
    check("header drive", rx[39:16], 24'hxxxxxx);
    check("first read byte", rx[15:8], 8'h1a);
    check("second read byte", rx[7:0], 8'h1b);
    check("writes during read", wrCount - wr0, 0);
    check("released after read", misoOeN, 1'b1);
  endtask
  // Full reset mid-run: the only way back to two-wire mode
  task automatic test_reset();
    int wr0;
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("mode during reset", modeOn, 1'b0);
    check("released in reset", misoOeN, 1'b1);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr0 = wrCount;
    host.frame(64'h00_01_23_11, 4, rx);
    check("writes after reset", wrCount - wr0, 0);
    check("mode after reset", modeOn, 1'b0);
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    test_mode();
    test_write();
    test_mismatch();
    test_read();
    check("mode kept", modeOn, 1'b1);
    test_reset();
    wrap_up();
  end
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end
endmodule
